// [rtl/slc_pkg.sv]
// package for the status log, command store and on/off pin qualifier
package slc_pkg;
    localparam int          CLK_MHZ       = 125;
    localparam int          LOG_WORDS     = 16;
    localparam int          LOG_BYTES     = 32;
    localparam logic [3:0]  LOG_LAST      = 4'hf;
    localparam logic [15:0] LOG_EMPTY     = 16'hffff;
    localparam logic [7:0]  CMD_LOG_READ  = 8'hdf;
    localparam logic [7:0]  CMD_POL_CFG   = 8'he3;
    localparam logic [7:0]  CMD_PIN_SETUP = 8'hf9;
    localparam logic [7:0]  CMD_ONOFF_CFG = 8'h02;
    localparam int          NCMD          = 8;
    localparam int          LOG_PERIOD_MS = 8000;
    localparam int          LOG_PERIOD_CYC = LOG_PERIOD_MS * 1000 * CLK_MHZ;
    localparam int          PIN_HOLD_US   = 150;
    localparam int          PIN_HOLD_CYC  = PIN_HOLD_US * CLK_MHZ;
    localparam int          HYST_MIN_MV   = 1000;
    localparam logic [7:0]  DEF_VALUE     = 8'h00;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_INIT   = 4'b0010,
        ST_RUN    = 4'b0100,
        ST_STORE  = 4'b1000
    } slc_state_e;
endpackage

// [rtl/slc_status_log_nvm_onoff.sv]
// status log, two command-value stores and on/off pin qualification
// Operation
// - log read returns counter plus fifteen words
// - logging starts after ramp with counter
// - status now, then every eight seconds until word fifteen is written
// - factory store read-only, restore-all reloads it
// - init loads active values, bus edits after
// - store-user-all writes active to user store
// - thresholdsValid flags turn-on at least 1V above turn-off
// - primary pin polarity selectable, default negative
// - secondary pin pull-up only when configured
// - secondary pin polarity selectable
// - feed-forward enable setting
// - power-cycle count is snapshot count plus one
`timescale 1ns/1ps
`default_nettype none
module slc_status_log_nvm_onoff
    import slc_pkg::*;
#(
    parameter int LOG_PERIOD = LOG_PERIOD_CYC,
    parameter int PIN_HOLD   = PIN_HOLD_CYC
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        srst,
    // ramp and status inputs
    input  wire logic        rampDone,
    input  wire logic [15:0] snapCycles,
    input  wire logic [15:0] statusWord,
    // log read port
    input  wire logic        logReadReq,
    input  wire logic [7:0]  logReadCmd,
    input  wire logic [4:0]  logByteIdx,
    output logic      [7:0]  logByte,
    output logic             logByteValid,
    // command store access
    input  wire logic        cmdWrite,
    input  wire logic [2:0]  cmdIdx,
    input  wire logic [7:0]  cmdData,
    input  wire logic        restoreDefaultAll,
    input  wire logic        storeUserAll,
    output logic      [7:0]  cmdValue,
    output logic             storeBusy,
    // configuration
    input  wire logic        primaryPolPositive,
    input  wire logic        secondaryPolPositive,
    input  wire logic        secondaryEnable,
    input  wire logic        secondaryPullupCfg,
    input  wire logic        feedForwardCfg,
    input  wire logic [15:0] vinOnMv,
    input  wire logic [15:0] vinOffMv,
    // pins
    input  wire logic        primaryOnOffPin,
    input  wire logic        secondaryOnOffPin,
    output logic             secondaryPullupEn,
    output logic             feedForwardEn,
    output logic             outputEnable,
    output logic             thresholdsValid
);
    typedef struct packed {
        slc_state_e  state;
        logic [LOG_WORDS-1:0][15:0] logMem;
        logic [3:0]  logCount;
        logic [31:0] periodCnt;
        logic [NCMD-1:0][7:0] active;
        logic [NCMD-1:0][7:0] user;
        logic [2:0]  initIdx;
        logic [7:0]  logByte;
        logic        logValid;
        logic [1:0]  priSync;
        logic [1:0]  secSync;
        logic        priState;
        logic [31:0] priCnt;
        logic        secState;
        logic        outEn;
        logic        started;
    } slc_regs_s;
    // arrays are packed so the whole state stays one packed struct
    slc_regs_s r_reg;
    slc_regs_s r_next;

    // factory store: constant, so writes can never reach it
    logic [NCMD-1:0][7:0] factory;
    always_comb begin
        for (int i = 0; i < NCMD; i++) begin
            factory[i] = DEF_VALUE + 8'(i);
        end
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic [15:0] w;
        logic        priOn;
        logic        secOn;
        w = 16'h0000;
        priOn = 1'b0;
        secOn = 1'b0;
        r_next = r_reg;
        r_next.priSync = {r_reg.priSync[0], primaryOnOffPin};
        r_next.secSync = {r_reg.secSync[0], secondaryOnOffPin};
        r_next.logValid = 1'b0;
        case (r_reg.state)
            ST_IDLE: begin
                r_next.state = ST_INIT;
            end
            ST_INIT: begin
                // user store is the power-up source
                r_next.active[r_reg.initIdx] = r_reg.user[r_reg.initIdx];
                r_next.initIdx = r_reg.initIdx + 3'h1;
                if (r_reg.initIdx == 3'(NCMD - 1)) begin
                    r_next.state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (cmdWrite) begin
                    r_next.active[cmdIdx] = cmdData;
                end
                if (restoreDefaultAll) begin
                    r_next.active = factory;
                end
                if (storeUserAll) begin
                    r_next.state = ST_STORE;
                end
            end
            ST_STORE: begin
                r_next.user = r_reg.active;
                r_next.state = ST_RUN;
            end
            default: begin
                r_next.state = ST_IDLE;
            end
        endcase

        // logging after ramp: counter word then status at once
        if (rampDone && !r_reg.started) begin
            r_next.started = 1'b1;
            r_next.logMem[0] = snapCycles + 16'h0001;
            r_next.logMem[1] = statusWord;
            r_next.logCount = 4'h2;
            r_next.periodCnt = 32'h0;
        end else if (r_reg.started && r_reg.logCount != 4'h0) begin
            if (r_reg.periodCnt == 32'(LOG_PERIOD - 1)) begin
                r_next.periodCnt = 32'h0;
                r_next.logMem[r_reg.logCount] = statusWord;
                r_next.logCount = (r_reg.logCount == LOG_LAST) ? 4'h0 : r_reg.logCount + 4'h1;
            end else begin
                r_next.periodCnt = r_reg.periodCnt + 32'h1;
            end
        end

        // 32-byte read, high byte first
        if (logReadReq && logReadCmd == CMD_LOG_READ) begin
            w = r_reg.logMem[logByteIdx[4:1]];
            r_next.logByte = logByteIdx[0] ? w[7:0] : w[15:8];
            r_next.logValid = 1'b1;
        end

        // primary pin: polarity select, change accepted after hold
        priOn = primaryPolPositive ? r_reg.priSync[1] : !r_reg.priSync[1];
        if (priOn == r_reg.priState) begin
            r_next.priCnt = 32'h0;
        end else if (r_reg.priCnt == 32'(PIN_HOLD - 1)) begin
            r_next.priState = priOn;
            r_next.priCnt = 32'h0;
        end else begin
            r_next.priCnt = r_reg.priCnt + 32'h1;
        end
        secOn = secondaryPolPositive ? r_reg.secSync[1] : !r_reg.secSync[1];
        r_next.secState = secondaryEnable ? secOn : 1'b1;
        r_next.outEn = r_reg.priState && r_reg.secState
                       && (r_reg.state == ST_RUN || r_reg.state == ST_STORE);
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            r_reg.state <= ST_IDLE;
            for (int i = 0; i < LOG_WORDS; i++) begin
                r_reg.logMem[i] <= LOG_EMPTY;
            end
            r_reg.logCount <= 4'h0;
            r_reg.periodCnt <= 32'h0;
            r_reg.initIdx <= 3'h0;
            r_reg.logByte <= 8'h00;
            r_reg.logValid <= 1'b0;
            r_reg.priSync <= 2'h3;
            r_reg.secSync <= 2'h3;
            r_reg.priState <= 1'b0;
            r_reg.priCnt <= 32'h0;
            r_reg.secState <= 1'b0;
            r_reg.outEn <= 1'b0;
            r_reg.started <= 1'b0;
            for (int i = 0; i < NCMD; i++) begin
                r_reg.active[i] <= DEF_VALUE + 8'(i);
            end
            r_reg.user <= r_reg.user; // non-volatile: survives reset
        end else begin
            r_reg <= r_next;
        end
    end

    assign logByte           = r_reg.logByte;
    assign logByteValid      = r_reg.logValid;
    assign cmdValue          = r_reg.active[cmdIdx];
    assign storeBusy         = (r_reg.state == ST_STORE);
    assign secondaryPullupEn = secondaryEnable && secondaryPullupCfg;
    assign feedForwardEn     = feedForwardCfg;
    assign outputEnable      = r_reg.outEn;
    // one extra bit so a high turn-off level cannot wrap the sum
    assign thresholdsValid   = ({1'b0, vinOnMv} >= {1'b0, vinOffMv} + 17'(HYST_MIN_MV));

    // ****************************************
    // checks
    // ****************************************
    a_read_byte_valid: assert property (@(posedge sys_clk) disable iff (srst)
        logReadReq && logReadCmd == CMD_LOG_READ |=> logByteValid)
        else $error("log read gave no byte");
    a_read_other_cmd: assert property (@(posedge sys_clk) disable iff (srst)
        !(logReadReq && logReadCmd == CMD_LOG_READ) |=> !logByteValid)
        else $error("byte valid without log read");
    a_counter_word: assert property (@(posedge sys_clk) disable iff (srst)
        rampDone && !r_reg.started |=> r_reg.logMem[0] == $past(snapCycles) + 16'h0001)
        else $error("counter word not snapshot plus one");
    a_first_status: assert property (@(posedge sys_clk) disable iff (srst)
        rampDone && !r_reg.started |=> r_reg.logMem[1] == $past(statusWord) && r_reg.logCount == 4'h2)
        else $error("first status not logged at once");
    sequence s_log_due;
        r_reg.started && r_reg.logCount != 4'h0 && r_reg.periodCnt == 32'(LOG_PERIOD - 1);
    endsequence
    a_period_log: assert property (@(posedge sys_clk) disable iff (srst)
        s_log_due |=> r_reg.logMem[$past(r_reg.logCount)] == $past(statusWord))
        else $error("periodic status not logged");
    a_no_log_early: assert property (@(posedge sys_clk) disable iff (srst)
        !r_reg.started |=> r_reg.logCount == 4'h0 || r_reg.started)
        else $error("logging before ramp");
    a_store_copies: assert property (@(posedge sys_clk) disable iff (srst)
        r_reg.state == ST_STORE |=> r_reg.user == $past(r_reg.active))
        else $error("store did not copy values");
    a_restore_factory: assert property (@(posedge sys_clk) disable iff (srst)
        r_reg.state == ST_RUN && restoreDefaultAll |=> r_reg.active == factory)
        else $error("restore missed factory values");
    a_pullup_gate: assert property (@(posedge sys_clk) disable iff (srst)
        !secondaryPullupCfg |-> !secondaryPullupEn)
        else $error("pull-up without setup");
    a_pri_hold: assert property (@(posedge sys_clk) disable iff (srst)
        $changed(r_reg.priState) |-> $past(r_reg.priCnt) == 32'(PIN_HOLD - 1))
        else $error("pin change taken before hold time");
endmodule
`default_nettype wire

// [tb/slc_onoff_switch.sv]
// external on/off switch driving the primary and secondary pins
`timescale 1ns/1ps
`default_nettype none
// ********
// switch model
// ********
module slc_onoff_switch #(
    parameter int HOLD = 4
) (
    // requests from the bench
    input  wire logic sys_clk,
    input  wire logic primaryWant,
    input  wire logic secondaryWant,
    // pins, high means left open
    output logic      primaryOnOffPin,
    output logic      secondaryOnOffPin
);
    int   heldCnt  = 0;
    logic priLevel = 1'b1;
    logic secLevel = 1'b1;
    // a new primary level waits until the old one has stood its full hold time; the secondary level follows the request at once
    always @(posedge sys_clk) begin
        if (heldCnt < HOLD) begin
            heldCnt <= heldCnt + 1;
        end else if (primaryWant != priLevel) begin
            priLevel <= primaryWant;
            heldCnt  <= 0;
        end
        secLevel <= secondaryWant;
    end
    assign primaryOnOffPin   = priLevel;
    assign secondaryOnOffPin = secLevel;
endmodule
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the status log, command stores and on/off pins
`timescale 1ns/1ps
`default_nettype none
// ********
// bench top
// ********
module testbench;
    import slc_pkg::*;
    localparam int PERIOD = 20;
    localparam int HOLD   = 4;
    logic        sys_clk = 0, srst = 1, rampDone = 0, logReadReq = 0, cmdWrite = 0;
    logic        restoreDefaultAll = 0, storeUserAll = 0, logByteValid, storeBusy;
    logic        primaryPolPositive = 0, secondaryPolPositive = 0, secondaryEnable = 0;
    logic        secondaryPullupCfg = 0, feedForwardCfg = 0, primaryOnOffPin, secondaryOnOffPin;
    logic        secondaryPullupEn, feedForwardEn, outputEnable, thresholdsValid;
    logic        primaryWant = 1, secondaryWant = 1;
    logic [15:0] snapCycles = 0, statusWord = 0, vinOnMv = 0, vinOffMv = 0;
    logic [7:0]  logReadCmd = 0, cmdData = 0, logByte, cmdValue;
    logic [4:0]  logByteIdx = 0;
    logic [2:0]  cmdIdx = 0;
    int          mismatches = 0, num_checks = 0, cycles = 0;

    slc_status_log_nvm_onoff #(.LOG_PERIOD(PERIOD), .PIN_HOLD(HOLD)) slc_status_log_nvm_onoff_i (
        .sys_clk, .srst, .rampDone, .snapCycles, .statusWord, .logReadReq, .logReadCmd,
        .logByteIdx, .logByte, .logByteValid, .cmdWrite, .cmdIdx, .cmdData, .restoreDefaultAll,
        .storeUserAll, .cmdValue, .storeBusy, .primaryPolPositive, .secondaryPolPositive,
        .secondaryEnable, .secondaryPullupCfg, .feedForwardCfg, .vinOnMv, .vinOffMv,
        .primaryOnOffPin, .secondaryOnOffPin, .secondaryPullupEn, .feedForwardEn,
        .outputEnable, .thresholdsValid);
    slc_onoff_switch #(.HOLD(HOLD)) slc_onoff_switch_i (
        .sys_clk, .primaryWant, .secondaryWant, .primaryOnOffPin, .secondaryOnOffPin);

    initial forever #4 sys_clk = ~sys_clk;

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // the limit sits far above the few hundred cycles the tests take
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            end_of_test;
        end
    end

    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic isOn(input logic pol, input logic pin);
        return pol ? pin : ~pin;
    endfunction
    // request stays up so that byte reads run back to back
    task automatic readLog(input logic [7:0] cmd, input logic [4:0] idx);
        logReadReq = 1'b1;
        logReadCmd = cmd;
        logByteIdx = idx;
        tick;
    endtask
    task automatic chkWord(input int k, input logic [15:0] w);
        for (int i = 0; i < 2; i++) begin
            readLog(CMD_LOG_READ, 5'(2 * k + i));
            chk({15'h0, logByteValid}, 16'h1);
            chk({8'h0, logByte}, {8'h0, i ? w[7:0] : w[15:8]});
        end
        logReadReq = 1'b0;
        tick;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick;
        s = 1'b0;
    endtask

    initial begin
        logic [15:0] stat;
        logic [7:0]  v;
        logic [2:0]  k;
        void'($urandom(32'h0008));
        repeat (2) tick;
        srst = 0;
        repeat (12) tick;
        stat = 16'($urandom);
        statusWord = stat;
        snapCycles = 16'($urandom);
        chkWord(1, LOG_EMPTY);
        rampDone = 1'b1;
        tick;
        chkWord(0, snapCycles + 16'h1);
        chkWord(1, stat);
        chkWord(2, LOG_EMPTY);
        readLog(8'hde, 5'h0);
        chk({15'h0, logByteValid}, 16'h0);
        logReadReq = 1'b0;
        repeat (14 * PERIOD + 10) tick;
        statusWord = ~stat;
        chkWord(15, stat);
        repeat (2 * PERIOD) tick;
        chkWord(15, stat);
        pulse(restoreDefaultAll);
        for (int i = 0; i < NCMD; i++) begin
            cmdIdx = 3'(i);
            tick;
            chk({8'h0, cmdValue}, {8'h0, DEF_VALUE + 8'(i)});
        end
        k = 3'($urandom);
        v = 8'($urandom);
        cmdIdx = k;
        cmdData = ~v;
        restoreDefaultAll = 1'b1;
        pulse(cmdWrite);
        restoreDefaultAll = 1'b0;
        chk({8'h0, cmdValue}, {8'h0, DEF_VALUE + 8'(k)});
        tick;
        cmdData = v;
        pulse(cmdWrite);
        chk({8'h0, cmdValue}, {8'h0, v});
        pulse(storeUserAll);
        chk({15'h0, storeBusy}, 16'h1);
        tick;
        chk({15'h0, storeBusy}, 16'h0);
        repeat (20) tick;
        cmdData = ~v;
        pulse(cmdWrite);
        for (int i = 0; i < 4; i++) begin
            {secondaryEnable, secondaryPullupCfg} = 2'(i);
            feedForwardCfg = i[0];
            vinOffMv = 16'($urandom_range(30000));
            vinOnMv = vinOffMv + 16'(HYST_MIN_MV) - 16'(i[1]);
            tick;
            chk({15'h0, secondaryPullupEn}, {15'h0, i == 3});
            chk({15'h0, feedForwardEn}, {15'h0, i[0]});
            chk({15'h0, thresholdsValid}, {15'h0, !i[1]});
        end
        secondaryEnable = 1'b0;
        for (int i = 0; i < 8; i++) begin
            {secondaryEnable, primaryPolPositive, primaryWant} = 3'(i ^ 2);
            secondaryPolPositive = i[1];
            secondaryWant = 1'($urandom);
            repeat (25) tick;
            chk({15'h0, outputEnable}, {15'h0, isOn(primaryPolPositive, primaryWant)
                & (!secondaryEnable | isOn(secondaryPolPositive, secondaryWant))});
        end
        srst = 1'b1;
        repeat (2) tick;
        srst = 1'b0;
        repeat (12) tick;
        chk({8'h0, cmdValue}, {8'h0, v});
        cmdIdx = k + 3'h1;
        tick;
        chk({8'h0, cmdValue}, {8'h0, DEF_VALUE + 8'(k + 3'h1)});
        end_of_test;
    end
endmodule
`default_nettype wire
